// ---- hdl/ckg_top.sv ----
// clock generator: oscillator control, start-up sequencing and cpu prescaler
// What this block does
// - high-speed oscillator runs after reset, software-stoppable
// - low-speed clock feeds only watchdog and H1
// - option strap decides if low-speed is stoppable
// - low-speed starts at reset, clocks enabled watchdog
// - cpu clock is prescaled main system clock
// - cpu boots on high-speed internal, no crystal wait
// - reset held until supply passes chosen threshold
// - cpu start waits supply stabilization time
// - early high threshold still gets remaining wait
// - poll status on internal; auto wait on crystal
// - unused clocks stoppable; stop halts both high-speed
// - clock pins are input ports after reset
// - ext select 0, pin enable 1: oscillation
// - clearing halt bit starts the crystal
// - status steps set in order, cleared by halt
// - reset loads longest stabilization selection
// - both bits 1: external clock input mode
// - setting halt bit stops crystal or input
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "ckg_consts.svh"
module ckg_top #(
	parameter int VSTAB_CYC = `CKG_VSTAB_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic crystal_pin_a,
	input wire logic crystal_pin_b,
	input wire logic supply_low_ok,
	input wire logic supply_high_ok,
	input wire logic opt_ls_stoppable,
	input wire logic opt_wdt_en,
	input wire logic lowvolt_default_start,
	input wire logic stop_req,
	input wire logic standby_exit,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic wdt_clk_en,
	output logic tmh1_clk_en,
	output logic cpu_run,
	output logic xtal_amp_en
);
	ckg_pkg::ckg_top_state_type s_q;
	ckg_pkg::ckg_top_state_type s_d;

	logic [3:0] pins_sync;
	logic [4:0] stab_status;
	logic stab_done;
	logic xtal_on;
	logic xtal_tick;
	logic xtal_ready;
	logic ihs_on;
	logic ls_on;
	logic main_tick;
	logic [3:0] pre_mask;
	logic pre_wrap;
	logic new_ready;
	logic xtal_level;

	ckg_sync3 #(
		.WIDTH(4)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin_in({supply_high_ok, supply_low_ok, crystal_pin_b, crystal_pin_a}),
		.pin_out(pins_sync)
	);

	ckg_stab_cnt u_stab (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.tick(xtal_tick && !s_q.ext_sel),
		.clear(!xtal_on),
		.sel(s_q.stab_sel),
		.status(stab_status),
		.done(stab_done)
	);

	always_comb begin
		// crystal runs only with pins enabled, halt cleared and no standby
		xtal_on = s_q.pin_en && !s_q.halt && !s_q.standby
			&& (s_q.st == ckg_pkg::CKG_RUN);
		// external mode takes the clock on pin b, pin a stays a port
		xtal_level = s_q.ext_sel ? pins_sync[1] : pins_sync[0];
		xtal_tick = xtal_on && xtal_level && !s_q.xtal_prev;
		xtal_ready = xtal_on && (s_q.ext_sel || stab_done);
		ihs_on = !s_q.ihs_stop && !s_q.standby && (s_q.st == ckg_pkg::CKG_RUN);
		ls_on = !(s_q.ils_stop && s_q.opt_ls_stoppable)
			&& (s_q.st == ckg_pkg::CKG_RUN);
		// low-speed clock never enters this mux
		main_tick = s_q.mclk_eff ? xtal_tick : ihs_on;
		pre_mask = 4'hF >> (3'h4 - s_q.div_eff);
		pre_wrap = main_tick && ((s_q.pre_cnt & pre_mask) == pre_mask);
		new_ready = s_q.mclk_req ? xtal_ready : !s_q.ihs_stop;
	end

	always_comb begin
		s_d = s_q;
		s_d.cpu_clk_en = 1'b0;
		s_d.periph_clk_en = 1'b0;
		s_d.wdt_clk_en = 1'b0;
		s_d.tmh1_clk_en = 1'b0;
		s_d.rd_data = 8'h00;
		s_d.xtal_prev = xtal_level;

		// straps sampled once, after reset release
		if (!s_q.opt_caught) begin
			s_d.opt_caught = 1'b1;
			s_d.opt_ls_stoppable = opt_ls_stoppable;
			s_d.opt_wdt_en = opt_wdt_en;
			s_d.opt_lv_start = lowvolt_default_start;
		end

		// power-up sequencing; analog thresholds arrive as comparator pins
		case (s_q.st)
			ckg_pkg::CKG_POR_HOLD: begin
				s_d.vcnt = 20'h00000;
				// a supply dip is a reset too, so controls fall back to reset values
				s_d.ihs_stop = 1'b0;
				s_d.ils_stop = 1'b0;
				s_d.pin_en = 1'b0;
				s_d.ext_sel = 1'b0;
				s_d.halt = `CKG_RST_HALT;
				s_d.mclk_req = 1'b0;
				s_d.mclk_eff = 1'b0;
				s_d.div_sel = `CKG_RST_CPUDIV;
				s_d.div_eff = `CKG_RST_CPUDIV;
				s_d.pre_cnt = 4'h0;
				s_d.stab_sel = `CKG_RST_STABSEL;
				s_d.standby = 1'b0;
				s_d.stop_wait = 1'b0;
				s_d.ls_cnt = 10'h000;
				if (pins_sync[2] && s_q.opt_caught) begin
					s_d.st = ckg_pkg::CKG_VOLT_WAIT;
				end
			end
			ckg_pkg::CKG_VOLT_WAIT: begin
				if (s_q.vcnt < VSTAB_CYC[19:0]) begin
					s_d.vcnt = s_q.vcnt + 20'h00001;
				end
				// with the high-level option, the full wait still runs out
				if (!pins_sync[2]) begin
					s_d.st = ckg_pkg::CKG_POR_HOLD;
				end else if ((s_q.vcnt >= VSTAB_CYC[19:0])
					&& (!s_q.opt_lv_start || pins_sync[3])) begin
					s_d.st = ckg_pkg::CKG_RUN;
				end
			end
			ckg_pkg::CKG_RUN: begin
				if (!pins_sync[2]) begin
					s_d.st = ckg_pkg::CKG_POR_HOLD;
				end
			end
			default: begin
				s_d.st = ckg_pkg::CKG_POR_HOLD;
			end
		endcase
		s_d.cpu_run = (s_d.st == ckg_pkg::CKG_RUN);

		// low-speed divider for watchdog and timer H1
		if (ls_on) begin
			if (s_q.ls_cnt == 10'(`CKG_LS_DIV - 1)) begin
				s_d.ls_cnt = 10'h000;
				s_d.tmh1_clk_en = 1'b1;
				s_d.wdt_clk_en = s_q.opt_wdt_en;
			end else begin
				s_d.ls_cnt = s_q.ls_cnt + 10'h001;
			end
		end

		// standby entry halts both high-speed clocks
		if (stop_req && s_q.cpu_run) begin
			s_d.standby = 1'b1;
		end else if (standby_exit && s_q.standby) begin
			s_d.standby = 1'b0;
			// on crystal the cpu waits the selected time by itself
			s_d.stop_wait = s_q.mclk_eff;
		end
		// external clock is ready at once, so the wait clears one cycle after exit; a main tick in that cycle gives no cpu tick
		if (s_q.stop_wait && xtal_ready) begin
			s_d.stop_wait = 1'b0;
		end

		// prescaler; source and ratio change only at a period boundary
		if (main_tick) begin
			s_d.periph_clk_en = 1'b1;
			s_d.pre_cnt = s_q.pre_cnt + 4'h1;
		end
		if (pre_wrap) begin
			s_d.pre_cnt = 4'h0;
			s_d.cpu_clk_en = !s_q.stop_wait && !s_q.standby;
			s_d.div_eff = s_q.div_sel;
			if ((s_q.mclk_req != s_q.mclk_eff) && new_ready) begin
				s_d.mclk_eff = s_q.mclk_req;
			end
		end
		s_d.xtal_amp_en = xtal_on && !s_q.ext_sel && s_d.cpu_run;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				`CKG_ADR_IOSC: begin
					// a clock feeding the cpu cannot be stopped
					if (s_q.mclk_eff || !reg_wdata[`CKG_BIT_IHS_STOP]) begin
						s_d.ihs_stop = reg_wdata[`CKG_BIT_IHS_STOP];
					end
					s_d.ils_stop = reg_wdata[`CKG_BIT_ILS_STOP];
				end
				`CKG_ADR_PINCTL: begin
					// pin mode is frozen while the crystal runs
					if (!xtal_on) begin
						s_d.pin_en = reg_wdata[`CKG_BIT_PIN_EN];
						s_d.ext_sel = reg_wdata[`CKG_BIT_EXT_SEL];
					end
				end
				`CKG_ADR_MAINCTL: begin
					if (!s_q.mclk_eff || !reg_wdata[`CKG_BIT_HALT]) begin
						s_d.halt = reg_wdata[`CKG_BIT_HALT];
					end
				end
				`CKG_ADR_CLKMODE: begin
					s_d.mclk_req = reg_wdata[`CKG_BIT_MCLK_REQ];
				end
				`CKG_ADR_CPUDIV: begin
					if (reg_wdata[2:0] <= `CKG_MAX_CPUDIV) begin
						s_d.div_sel = reg_wdata[2:0];
					end
				end
				`CKG_ADR_STABSEL: begin
					s_d.stab_sel = reg_wdata[2:0];
				end
				default: begin
				end
			endcase
		end

		// register reads, data valid the cycle after the strobe
		if (reg_rd) begin
			case (reg_addr)
				`CKG_ADR_IOSC: begin
					s_d.rd_data[`CKG_BIT_IHS_STOP] = s_q.ihs_stop;
					s_d.rd_data[`CKG_BIT_ILS_STOP] = s_q.ils_stop;
					s_d.rd_data[`CKG_BIT_IHS_RUN] = ihs_on;
				end
				`CKG_ADR_PINCTL: begin
					s_d.rd_data[`CKG_BIT_PIN_EN] = s_q.pin_en;
					s_d.rd_data[`CKG_BIT_EXT_SEL] = s_q.ext_sel;
				end
				`CKG_ADR_MAINCTL: begin
					s_d.rd_data[`CKG_BIT_HALT] = s_q.halt;
				end
				`CKG_ADR_CLKMODE: begin
					s_d.rd_data[`CKG_BIT_MCLK_REQ] = s_q.mclk_req;
					s_d.rd_data[`CKG_BIT_MCLK_EFF] = s_q.mclk_eff;
				end
				`CKG_ADR_CPUDIV: begin
					s_d.rd_data[2:0] = s_q.div_sel;
				end
				`CKG_ADR_STABSTAT: begin
					s_d.rd_data[4:0] = stab_status;
				end
				`CKG_ADR_STABSEL: begin
					s_d.rd_data[2:0] = s_q.stab_sel;
				end
				`CKG_ADR_PORT: begin
					// pin a is a port unless oscillating; pin b only when unused
					s_d.rd_data[0] = (s_q.pin_en && !s_q.ext_sel) ? 1'b0 : pins_sync[0];
					s_d.rd_data[1] = s_q.pin_en ? 1'b0 : pins_sync[1];
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
			s_q.st <= ckg_pkg::CKG_POR_HOLD;
			s_q.halt <= `CKG_RST_HALT;
			s_q.div_sel <= `CKG_RST_CPUDIV;
			s_q.div_eff <= `CKG_RST_CPUDIV;
			s_q.stab_sel <= `CKG_RST_STABSEL;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rd_data;
	assign cpu_clk_en = s_q.cpu_clk_en;
	assign periph_clk_en = s_q.periph_clk_en;
	assign wdt_clk_en = s_q.wdt_clk_en;
	assign tmh1_clk_en = s_q.tmh1_clk_en;
	assign cpu_run = s_q.cpu_run;
	assign xtal_amp_en = s_q.xtal_amp_en;
endmodule

// ---- hdl/ckg_consts.svh ----
// constants of the clock generator: offsets, fields, reset values, timing
`ifndef CKG_CONSTS_SVH
`define CKG_CONSTS_SVH

`define CKG_SYS_MHZ 125
`define CKG_SYS_KHZ 125000
`define CKG_LS_KHZ 240
`define CKG_LS_DIV ((`CKG_SYS_KHZ + `CKG_LS_KHZ / 2) / `CKG_LS_KHZ)
`define CKG_VSTAB_US 3700
`define CKG_VSTAB_CYC (`CKG_VSTAB_US * `CKG_SYS_MHZ)

`define CKG_ADR_IOSC 3'h0
`define CKG_ADR_PINCTL 3'h1
`define CKG_ADR_MAINCTL 3'h2
`define CKG_ADR_CLKMODE 3'h3
`define CKG_ADR_CPUDIV 3'h4
`define CKG_ADR_STABSTAT 3'h5
`define CKG_ADR_STABSEL 3'h6
`define CKG_ADR_PORT 3'h7

`define CKG_BIT_IHS_STOP 0
`define CKG_BIT_ILS_STOP 1
`define CKG_BIT_IHS_RUN 7
`define CKG_BIT_PIN_EN 0
`define CKG_BIT_EXT_SEL 1
`define CKG_BIT_HALT 7
`define CKG_BIT_MCLK_REQ 0
`define CKG_BIT_MCLK_EFF 1

`define CKG_RST_HALT 1'b1
`define CKG_RST_CPUDIV 3'h1
`define CKG_MAX_CPUDIV 3'h4
`define CKG_RST_STABSEL 3'h5
`define CKG_RST_STABSTAT 5'h00

`endif

// ---- hdl/ckg_pkg.sv ----
// types of the clock generator top module ckg_top
package ckg_pkg;

	typedef enum logic [1:0] {
		CKG_POR_HOLD = 2'h0,
		CKG_VOLT_WAIT = 2'h1,
		CKG_RUN = 2'h3
	} ckg_rst_state_type;

	typedef struct packed {
		ckg_rst_state_type st;
		logic [19:0] vcnt;
		logic opt_caught;
		logic opt_ls_stoppable;
		logic opt_wdt_en;
		logic opt_lv_start;
		logic ihs_stop;
		logic ils_stop;
		logic pin_en;
		logic ext_sel;
		logic halt;
		logic mclk_req;
		logic mclk_eff;
		logic [2:0] div_sel;
		logic [2:0] div_eff;
		logic [3:0] pre_cnt;
		logic [2:0] stab_sel;
		logic standby;
		logic stop_wait;
		logic [9:0] ls_cnt;
		logic xtal_prev;
		logic cpu_clk_en;
		logic periph_clk_en;
		logic wdt_clk_en;
		logic tmh1_clk_en;
		logic cpu_run;
		logic xtal_amp_en;
		logic [7:0] rd_data;
	} ckg_top_state_type;

endpackage

// ---- hdl/ckg_sync3.sv ----
// three-flop pin synchroniser, output moves when the last two flops agree
`timescale 1ns/1ps
module ckg_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);
	typedef struct packed {
		logic [WIDTH-1:0] f1;
		logic [WIDTH-1:0] f2;
		logic [WIDTH-1:0] f3;
		logic [WIDTH-1:0] out;
	} ckg_sync_state_type;

	ckg_sync_state_type s_q;
	ckg_sync_state_type s_d;
	logic [WIDTH-1:0] agree;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// f1 feeds only f2; the filter looks at f2 and f3
			assign agree[i] = (s_q.f2[i] == s_q.f3[i]);
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		s_d.f1 = pin_in;
		s_d.f2 = s_q.f1;
		s_d.f3 = s_q.f2;
		s_d.out = (s_q.out & ~agree) | (s_q.f3 & agree);
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pin_out = s_q.out;
endmodule

// ---- hdl/ckg_stab_cnt.sv ----
// crystal stabilization counter with its five status steps
`timescale 1ns/1ps
`include "ckg_consts.svh"
module ckg_stab_cnt (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic clear,
	input wire logic [2:0] sel,
	output logic [4:0] status,
	output logic done
);
	typedef struct packed {
		logic [16:0] cnt;
		logic [4:0] status;
		logic done;
	} ckg_stab_state_type;

	ckg_stab_state_type s_q;
	ckg_stab_state_type s_d;
	logic [4:0] reached;
	logic [16:0] limit;

	// status bit 4 is the shortest step, bit 0 the longest
	function automatic logic [4:0] step_exp(input int idx);
		case (idx)
			4: step_exp = 5'h0B;
			3: step_exp = 5'h0D;
			2: step_exp = 5'h0E;
			1: step_exp = 5'h0F;
			default: step_exp = 5'h10;
		endcase
	endfunction

	// prohibited selections behave as the longest wait
	always_comb begin
		case (sel)
			3'h1: limit = 17'h00800;
			3'h2: limit = 17'h02000;
			3'h3: limit = 17'h04000;
			3'h4: limit = 17'h08000;
			default: limit = 17'h10000;
		endcase
	end

	genvar i;
	generate
		for (i = 0; i < 5; i++) begin : g_step
			assign reached[i] = (s_q.cnt >= (17'h00001 << step_exp(i)));
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		if (clear) begin
			s_d = '0;
		end else begin
			if (tick && (s_q.cnt < limit)) begin
				s_d.cnt = s_q.cnt + 17'h00001;
			end
			// counter stops at the selected wait, so status never passes it
			s_d.status = s_q.status | reached;
			s_d.done = (s_q.cnt >= limit);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign status = s_q.status;
	assign done = s_q.done;
endmodule

// ---- dv/ckg_top_assertions.sv ----
// port-level assertion checker for the clock generator, bound into ckg_top
`timescale 1ns/1ps
module ckg_top_assertions #(
	parameter int VSTAB_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic supply_low_ok,
	input wire logic opt_wdt_en,
	input wire logic stop_req,
	input wire logic standby_exit,
	input wire logic cpu_clk_en,
	input wire logic periph_clk_en,
	input wire logic wdt_clk_en,
	input wire logic tmh1_clk_en,
	input wire logic cpu_run,
	input wire logic xtal_amp_en
);
	// cycles with supply above the low threshold; saturates so it never wraps
	logic [31:0] up_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			up_q <= 32'h0;
		end else if (!supply_low_ok) begin
			up_q <= 32'h0;
		end else if (up_q != 32'hFFFFFFFF) begin
			up_q <= up_q + 32'h1;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_ls_only_timers: assert property (wdt_clk_en |-> tmh1_clk_en)
		else $error("watchdog tick without low-speed tick");
	a_wdt_strap_tick: assert property (tmh1_clk_en |-> wdt_clk_en == opt_wdt_en)
		else $error("watchdog tick does not follow strap");
	a_cpu_from_main: assert property (cpu_clk_en |-> periph_clk_en)
		else $error("cpu tick outside main clock tick");
	a_vstab_wait: assert property ($rose(cpu_run) |-> up_q >= VSTAB_CYC)
		else $error("cpu started before supply stabilization");
	a_boot_internal: assert property ($rose(cpu_run) |-> ##[0:6] cpu_clk_en)
		else $error("cpu clock missing after start");
	a_low_hold: assert property (!supply_low_ok [*8] |-> !cpu_run)
		else $error("running with supply below threshold");
	a_amp_idle: assert property (!cpu_run |-> !xtal_amp_en)
		else $error("crystal amplifier on before start");
	// only a standby that lasts is judged; an early exit may restart clocks
	a_stop_halts: assert property (stop_req && cpu_run ##1 !standby_exit [*6] |->
		(!cpu_clk_en && !periph_clk_en && !xtal_amp_en) [*3])
		else $error("clocks still running after stop");
endmodule

bind ckg_top ckg_top_assertions #(.VSTAB_CYC(VSTAB_CYC)) i_ckg_top_assertions (
	.sys_clk(sys_clk),
	.rst_b(rst_b),
	.supply_low_ok(supply_low_ok),
	.opt_wdt_en(opt_wdt_en),
	.stop_req(stop_req),
	.standby_exit(standby_exit),
	.cpu_clk_en(cpu_clk_en),
	.periph_clk_en(periph_clk_en),
	.wdt_clk_en(wdt_clk_en),
	.tmh1_clk_en(tmh1_clk_en),
	.cpu_run(cpu_run),
	.xtal_amp_en(xtal_amp_en)
);

// ---- dv/ckg_xtal_model.sv ----
// crystal resonator and external clock source facing the clock pins
`timescale 1ns/1ps
module ckg_xtal_model #(
	parameter int HALF = 2
) (
	input wire logic sys_clk,
	input wire logic amp_en,
	input wire logic ext_on,
	input wire logic port_a,
	input wire logic port_b,
	output logic pin_a,
	output logic pin_b
);
	logic osc = 1'b0;
	int cnt = 0;
	// swings only while driven; stands still otherwise
	always @(posedge sys_clk) begin
		if (amp_en || ext_on) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1) begin
				osc <= ~osc;
			end
		end
	end
	assign pin_a = amp_en ? osc : port_a;
	assign pin_b = ext_on ? osc : (amp_en ? ~osc : port_b);
endmodule

// ---- dv/ckg_top_tb.sv ----
// self-checking testbench of the clock generator
`timescale 1ns/1ps
module ckg_top_tb;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic supply_low_ok = 1'b0;
	logic supply_high_ok = 1'b0;
	logic stop_req = 1'b0;
	logic standby_exit = 1'b0;
	logic opt_ls_stoppable = 1'b0;
	logic opt_wdt_en = 1'b1;
	logic lowvolt_default_start = 1'b0;
	logic ext_on = 1'b0;
	logic port_a = 1'b1;
	logic port_b = 1'b0;
	logic [7:0] reg_rdata;
	logic pin_a, pin_b, cpu_clk_en, periph_clk_en, wdt_clk_en, tmh1_clk_en, cpu_run, xtal_amp_en;
	logic [7:0] rv;
	logic [15:0] cc, pc, tc, wc;
	logic [7:0] rst_tab [0:7] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h01, 8'h00, 8'h05, 8'h01};
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;

	ckg_top #(.VSTAB_CYC(20)) i_ckg_top (.sys_clk(sys_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .crystal_pin_a(pin_a), .crystal_pin_b(pin_b),
		.supply_low_ok(supply_low_ok), .supply_high_ok(supply_high_ok),
		.opt_ls_stoppable(opt_ls_stoppable), .opt_wdt_en(opt_wdt_en),
		.lowvolt_default_start(lowvolt_default_start),
		.stop_req(stop_req), .standby_exit(standby_exit), .cpu_clk_en(cpu_clk_en),
		.periph_clk_en(periph_clk_en), .wdt_clk_en(wdt_clk_en), .tmh1_clk_en(tmh1_clk_en),
		.cpu_run(cpu_run), .xtal_amp_en(xtal_amp_en));
	ckg_xtal_model #(.HALF(2)) i_ckg_xtal_model (.sys_clk(sys_clk), .amp_en(xtal_amp_en),
		.ext_on(ext_on), .port_a(port_a), .port_b(port_b), .pin_a(pin_a), .pin_b(pin_b));

	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	task end_of_test;
		if (mismatches == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// generous ceiling: the crystal wait alone is some 8k cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			end_of_test;
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [2:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task count(input int n);
		cc = 16'h0;
		pc = 16'h0;
		tc = 16'h0;
		wc = 16'h0;
		repeat (n) begin
			idle(1);
			cc = cc + {15'h0, cpu_clk_en};
			pc = pc + {15'h0, periph_clk_en};
			tc = tc + {15'h0, tmh1_clk_en};
			wc = wc + {15'h0, wdt_clk_en};
		end
	endtask
	task t_reset_vals;
		idle(8);
		for (int i = 0; i < 8; i++) begin
			rd(i[2:0]);
			chk({8'h0, rv}, {8'h0, rst_tab[i]});
		end
	endtask
	task t_powerup;
		@(posedge sys_clk);
		supply_low_ok <= 1'b1;
		supply_high_ok <= 1'b1;
		idle(20);
		chk({15'h0, cpu_run}, 16'h0);
		for (int i = 0; i < 40 && cpu_run !== 1'b1; i++) idle(1);
		chk({15'h0, cpu_run}, 16'h1);
		count(16);
		chk(cc, 16'h8);
		chk(pc, 16'h10);
		rd(3'h0);
		chk({8'h0, rv}, 16'h0080);
	endtask
	task t_div;
		// the last pass writes an illegal ratio, which must leave divide-by-16
		for (int n = 0; n < 6; n++) begin
			wr(3'h4, n[7:0]);
			idle(40);
			count(32);
			chk(cc, 16'h20 >> ((n > 4) ? 4 : n));
		end
		wr(3'h4, 8'h00);
	endtask
	task t_crystal;
		wr(3'h6, 8'h01);
		wr(3'h1, 8'h01);
		wr(3'h2, 8'h00);
		idle(8);
		chk({15'h0, xtal_amp_en}, 16'h1);
		rd(3'h7);
		chk({8'h0, rv}, 16'h0000);
		for (int i = 0; i < 300 && rv !== 8'h10; i++) begin
			idle(48);
			rd(3'h5);
		end
		idle(200);
		rd(3'h5);
		chk({8'h0, rv}, 16'h0010);
		wr(3'h3, 8'h01);
		idle(40);
		rd(3'h3);
		chk({8'h0, rv}, 16'h0003);
		count(40);
		chk(pc, 16'hA);
		chk(cc, 16'hA);
		wr(3'h2, 8'h80);
		idle(8);
		chk({15'h0, xtal_amp_en}, 16'h1);
		// internal oscillator stopped: switch back must wait for it
		wr(3'h0, 8'h01);
		wr(3'h3, 8'h00);
		idle(40);
		rd(3'h0);
		chk({8'h0, rv}, 16'h0001);
		rd(3'h3);
		chk({8'h0, rv}, 16'h0002);
		wr(3'h0, 8'h00);
		idle(40);
		wr(3'h3, 8'h00);
		idle(40);
		wr(3'h2, 8'h80);
		idle(8);
		chk({15'h0, xtal_amp_en}, 16'h0);
		rd(3'h5);
		chk({8'h0, rv}, 16'h0000);
	endtask
	task t_ext;
		ext_on <= 1'b1;
		wr(3'h1, 8'h03);
		wr(3'h2, 8'h00);
		idle(8);
		chk({15'h0, xtal_amp_en}, 16'h0);
		rd(3'h7);
		chk({8'h0, rv}, 16'h0001);
		wr(3'h3, 8'h01);
		idle(20);
		rd(3'h3);
		chk({8'h0, rv}, 16'h0003);
		// standby on the external clock: no stabilization wait on exit
		@(posedge sys_clk);
		stop_req <= 1'b1;
		@(posedge sys_clk);
		stop_req <= 1'b0;
		idle(8);
		@(posedge sys_clk);
		standby_exit <= 1'b1;
		@(posedge sys_clk);
		standby_exit <= 1'b0;
		idle(20);
		count(40);
		chk(cc, 16'hA);
		wr(3'h3, 8'h00);
		idle(40);
		wr(3'h2, 8'h80);
		ext_on <= 1'b0;
	endtask
	task t_stop;
		@(posedge sys_clk);
		stop_req <= 1'b1;
		@(posedge sys_clk);
		stop_req <= 1'b0;
		count(20);
		chk(cc, 16'h0);
		chk(pc, 16'h0);
		@(posedge sys_clk);
		standby_exit <= 1'b1;
		@(posedge sys_clk);
		standby_exit <= 1'b0;
		idle(10);
		count(16);
		chk(cc, 16'h10);
	endtask
	task t_low_speed;
		// strap makes low-speed unstoppable; hs stop refused while cpu uses it
		wr(3'h0, 8'h03);
		count(1042);
		chk(cc, 16'h412);
		chk(tc, 16'h2);
		chk(wc, 16'h2);
	endtask
	task t_por;
		// supply dip: internal reset brings the controls back
		@(posedge sys_clk);
		supply_low_ok <= 1'b0;
		idle(8);
		chk({15'h0, cpu_run}, 16'h0);
		rd(3'h6);
		chk({8'h0, rv}, 16'h0005);
		rd(3'h1);
		chk({8'h0, rv}, 16'h0000);
		rd(3'h4);
		chk({8'h0, rv}, 16'h0001);
	endtask
	task t_straps;
		// second reset: stoppable low-speed, no watchdog, high-level start
		@(posedge sys_clk);
		rst_b <= 1'b0;
		supply_low_ok <= 1'b1;
		supply_high_ok <= 1'b0;
		opt_ls_stoppable <= 1'b1;
		opt_wdt_en <= 1'b0;
		lowvolt_default_start <= 1'b1;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		idle(2);
		chk({15'h0, cpu_run}, 16'h0);
		idle(40);
		chk({15'h0, cpu_run}, 16'h0);
		@(posedge sys_clk);
		supply_high_ok <= 1'b1;
		for (int i = 0; i < 10 && cpu_run !== 1'b1; i++) idle(1);
		chk({15'h0, cpu_run}, 16'h1);
		wr(3'h0, 8'h02);
		count(600);
		chk(tc, 16'h0);
		wr(3'h0, 8'h00);
		count(521);
		chk(tc, 16'h1);
		chk(wc, 16'h0);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_reset_vals;
		t_powerup;
		t_div;
		t_crystal;
		t_ext;
		t_stop;
		t_low_speed;
		t_por;
		t_straps;
		end_of_test;
	end
endmodule
